// file: hw/sscf_top.sv
// Serial command frame slave of a two-axis acceleration sensor
`timescale 1ns/10ps
`default_nettype none
module sscf_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // Initialisation and fault sources
  input wire logic init_phase1,
  input wire logic init_busy,
  input wire logic osc_running,
  input wire logic osc_compare_fail,
  input wire logic temp_fault,
  input wire logic offset_x_fault,
  input wire logic offset_y_fault,
  input wire logic parity_fault,
  // Acceleration samples
  input wire logic [9:0] accel_x,
  input wire logic [9:0] accel_y,
  // Other registers
  output logic [4:0] ext_reg_addr,
  input wire logic [7:0] ext_reg_data,
  // Control outputs
  output logic filter_bypass_bit,
  output logic selftest_direction_bit,
  output logic selftest_enable_bit,
  output logic clear_fault_pulse,
  output logic restart_seen_flag
);

  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  typedef enum logic [1:0] {P_IDLE, P_LOOK, P_BUILD} sscf_proc_t;

  logic [sscf_pkg::SYNC_W-1:0] pins_s;
  logic sclk_q;
  logic csn_q;

  sscf_sync #(
    .W(sscf_pkg::SYNC_W),
    .RST_VAL(sscf_pkg::SYNC_RST)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({spi_sclk, spi_cs_n, spi_mosi}),
    .sync_out(pins_s)
  );

  wire sclk_s = pins_s[2];
  wire csn_s = pins_s[1];
  wire mosi_s = pins_s[0];
  wire sclk_rise = sclk_s & ~sclk_q;
  wire sclk_fall = ~sclk_s & sclk_q;
  wire cs_start = csn_q & ~csn_s;
  wire cs_end = ~csn_q & csn_s;
  wire in_frame = ~csn_s & ~csn_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
      csn_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      csn_q <= csn_s;
    end
  end

  // ****************************************************************
  // Frame shifter
  // ****************************************************************
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [4:0] cnt_q;
  logic ferr_q;
  logic [15:0] reply_q;

  wire [4:0] cnt_inc = (cnt_q == sscf_pkg::EDGE_SAT) ? cnt_q : cnt_q + 5'h01;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      cnt_q <= 5'h00;
      ferr_q <= 1'b0;
    end else if (cs_start) begin
      tx_q <= reply_q;
      cnt_q <= 5'h00;
      ferr_q <= sclk_s;
      rx_q <= 16'h0000;
    end else if (in_frame) begin
      if (sclk_rise) begin
        rx_q <= {rx_q[14:0], mosi_s};
        cnt_q <= cnt_inc;
      end
      if (sclk_fall) begin
        tx_q <= {tx_q[14:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // Frame hand-off into the buffer
  // ****************************************************************
  sscf_word_if #(.W(sscf_pkg::WORD_W)) push_if ();
  sscf_word_if #(.W(sscf_pkg::WORD_W)) pop_if ();

  wire frame_bad = ferr_q | sclk_s | (cnt_q != sscf_pkg::EDGE_COUNT);
  // frames in first init phase dropped
  assign push_if.valid = cs_end & ~init_phase1;
  assign push_if.data = {frame_bad, rx_q};

  sscf_buf #(
    .W(sscf_pkg::WORD_W),
    .D(sscf_pkg::BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .push(push_if),
    .pop(pop_if)
  );

  // ****************************************************************
  // Command decode
  // ****************************************************************
  sscf_proc_t state_q;
  logic [16:0] cmd_q;
  logic [7:0] ctrl_q;
  logic restart_q;
  logic nd_pend_q;

  // Reply word only changes between frames
  assign pop_if.ready = (state_q == P_IDLE) & csn_s & csn_q;

  wire c_bad = cmd_q[16];
  wire c_acc = cmd_q[13];
  wire [1:0] c_op = cmd_q[15:14];
  wire [4:0] c_addr = cmd_q[12:8];
  wire [7:0] c_dat = cmd_q[7:0];
  wire init_active = init_phase1 | init_busy;
  wire osc_fault = osc_running & osc_compare_fail;
  wire hpf_present = ~ctrl_q[sscf_pkg::CTL_FILTER_BYPASS_BIT] & ~ctrl_q[sscf_pkg::CTL_ST0];
  wire [7:0] stat_reg = {parity_fault, osc_fault, init_active, temp_fault,
                         hpf_present, offset_y_fault, offset_x_fault, restart_q};

  wire nd = init_active | nd_pend_q;
  wire he = temp_fault | offset_x_fault | offset_y_fault | parity_fault;
  wire wrong_condition_flag = cmd_q[15];
  wire acc_err = nd | he | wrong_condition_flag;
  wire [9:0] acc_flags = (10'(nd) << sscf_pkg::FLG_ND) | (10'(he) << sscf_pkg::FLG_HE) |
                         (10'(wrong_condition_flag) << sscf_pkg::FLG_CNC);
  wire [1:0] good_status = ctrl_q[sscf_pkg::CTL_ST0] ? sscf_pkg::ST_SELF : sscf_pkg::ST_DATA;
  wire [1:0] acc_status = acc_err ? sscf_pkg::ST_ERR : good_status;
  wire [9:0] acc_sample = cmd_q[14] ? accel_y : accel_x;
  wire [15:0] acc_word = {2'h0, cmd_q[14], 1'b0, acc_status, acc_err ? acc_flags : acc_sample};

  wire wr_ok = (c_op == sscf_pkg::OP_WRITE) & (c_addr == sscf_pkg::CTRL_ADDR);
  wire req_err = ~c_acc & ((c_op == sscf_pkg::OP_NONE) | ((c_op == sscf_pkg::OP_WRITE) & ~wr_ok));
  wire [7:0] ctrl_new = c_dat & sscf_pkg::CTRL_RB_MASK;
  wire [7:0] rd_val = (c_addr == sscf_pkg::STAT_ADDR) ? stat_reg :
                      (c_addr == sscf_pkg::CTRL_ADDR) ? ctrl_q : ext_reg_data;
  wire op_write = (c_op == sscf_pkg::OP_WRITE);
  wire op_test = (c_op == sscf_pkg::OP_TEST);
  wire [7:0] ok_data = op_test ? stat_reg : rd_val;
  wire [7:0] na_data = op_write ? ctrl_new : ok_data;
  wire [15:0] na_word = {cmd_q[15:13], 1'b0, sscf_pkg::ST_DATA, 2'h0, na_data};
  wire [15:0] raw_reply = c_bad ? sscf_pkg::SPI_ERR_RAW :
                          req_err ? sscf_pkg::REQ_ERR_RAW :
                          c_acc ? acc_word : na_word;
  wire [15:0] reply_d = sscf_pkg::add_parity(raw_reply);
  wire do_write = ~c_bad & ~c_acc & wr_ok;
  wire do_clear = do_write & c_dat[sscf_pkg::CTL_CE];

  // ****************************************************************
  // Command processor
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= P_IDLE;
      cmd_q <= 17'h00000;
      ext_reg_addr <= 5'h00;
    end else begin
      case (state_q)
        P_IDLE: begin
          if (pop_if.valid & pop_if.ready) begin
            cmd_q <= pop_if.data;
            ext_reg_addr <= pop_if.data[12:8];
            state_q <= P_LOOK;
          end
        end
        P_LOOK: begin
          state_q <= P_BUILD;
        end
        P_BUILD: begin
          state_q <= P_IDLE;
        end
        default: begin
          state_q <= P_IDLE;
        end
      endcase
    end
  end

  wire build = (state_q == P_BUILD);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reply_q <= sscf_pkg::REQ_ERR_WORD;
      ctrl_q <= sscf_pkg::CTRL_RST;
      clear_fault_pulse <= 1'b0;
      restart_q <= 1'b1;
      nd_pend_q <= 1'b1;
    end else begin
      clear_fault_pulse <= build & do_clear;
      if (build) begin
        reply_q <= reply_d;
        if (do_write) begin
          ctrl_q <= ctrl_new;
        end
        if (do_clear & ~init_active) begin
          restart_q <= 1'b0;
        end
        if (~c_bad & c_acc & ~init_active) begin
          nd_pend_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  // oscillator fault forces high
  wire miso_d = osc_fault | tx_q[15];
  wire miso_oe_d = in_frame & ~init_phase1;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso <= miso_d;
      spi_miso_oe <= miso_oe_d;
    end
  end

  assign filter_bypass_bit = ctrl_q[sscf_pkg::CTL_FILTER_BYPASS_BIT];
  assign selftest_direction_bit = ctrl_q[sscf_pkg::CTL_ST1];
  assign selftest_enable_bit = ctrl_q[sscf_pkg::CTL_ST0];
  assign restart_seen_flag = restart_q;

endmodule : sscf_top
`default_nettype wire

// file: hw/sscf_pkg.sv
// Constants, reply layouts and helpers shared by the sensor serial command frame block
package sscf_pkg;

  // ****************************************************************
  // Frame and synchroniser shape
  // ****************************************************************
  localparam int FRAME_BITS = 16;
  localparam int WORD_W = 17;
  localparam int BUF_DEPTH = 2;
  localparam int SYNC_W = 3;
  localparam logic [4:0] EDGE_COUNT = 5'h10;
  localparam logic [4:0] EDGE_SAT = 5'h1F;
  localparam logic [2:0] SYNC_RST = 3'h2;

  // ****************************************************************
  // Register addresses and control bit positions
  // ****************************************************************
  localparam logic [4:0] CTRL_ADDR = 5'h00;
  localparam logic [4:0] STAT_ADDR = 5'h10;
  localparam int CTL_ST0 = 0;
  localparam int CTL_ST1 = 1;
  localparam int CTL_FILTER_BYPASS_BIT = 2;
  localparam int CTL_CE = 3;
  localparam logic [7:0] CTRL_RB_MASK = 8'h07;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // ****************************************************************
  // Command operations, reply status codes and error flags
  // ****************************************************************
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_TEST = 2'h3;
  localparam logic [1:0] ST_DATA = 2'h1;
  localparam logic [1:0] ST_SELF = 2'h2;
  localparam logic [1:0] ST_ERR = 2'h3;
  localparam int FLG_ND = 4;
  localparam int FLG_HE = 3;
  localparam int FLG_CNC = 2;
  localparam int FLG_SPI = 1;
  localparam int FLG_REQ = 0;
  localparam int RPL_PAR = 12;

  // Inserts odd parity over the whole word
  function automatic logic [15:0] add_parity(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    r[RPL_PAR] = 1'b0;
    r[RPL_PAR] = ~^r;
    return r;
  endfunction : add_parity

  localparam logic [15:0] REQ_ERR_RAW = {4'h0, ST_ERR, 10'h001};
  localparam logic [15:0] SPI_ERR_RAW = {4'h0, ST_ERR, 10'h002};
  localparam logic [15:0] REQ_ERR_WORD = add_parity(REQ_ERR_RAW);

endpackage : sscf_pkg

// file: hw/sscf_word_if.sv
// Valid/ready word carrier between the frame logic and the buffer
`timescale 1ns/10ps
`default_nettype none
interface sscf_word_if #(parameter int W = 17);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sscf_word_if
`default_nettype wire

// file: hw/sscf_sync.sv
// Two-flop synchronisers for the serial pins
`timescale 1ns/10ps
`default_nettype none
module sscf_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins and synchronised levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic stab_q;
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          meta_q <= RST_VAL[i];
          stab_q <= RST_VAL[i];
        end else begin
          meta_q <= async_in[i];
          stab_q <= meta_q;
        end
      end
      assign sync_out[i] = stab_q;
    end
  endgenerate
endmodule : sscf_sync
`default_nettype wire

// file: hw/sscf_buf.sv
// Two-entry valid/ready buffer for received frame words
`timescale 1ns/10ps
`default_nettype none
module sscf_buf #(
  parameter int W = 17,
  parameter int D = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Filling and draining sides
  sscf_word_if.snk push,
  sscf_word_if.src pop
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = AW + 1;
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  wire do_push = push.valid & push.ready;
  wire do_pop = pop.valid & pop.ready;

  assign push.ready = (cnt_q != CW'(D));
  assign pop.valid = (cnt_q != '0);
  assign pop.data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wr_q] <= push.data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (do_pop) begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule : sscf_buf
`default_nettype wire

// file: verification/sscf_top_asserts.sv
// Checker on the serial slave top ports
`timescale 1ns/10ps
`default_nettype none
module sscf_top_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial pins
  input wire logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  // Status inputs
  input wire logic init_phase1,
  input wire logic init_busy,
  input wire logic osc_running,
  input wire logic osc_compare_fail,
  // Control outputs
  input wire logic filter_bypass_bit,
  input wire logic selftest_direction_bit,
  input wire logic selftest_enable_bit,
  input wire logic clear_fault_pulse,
  input wire logic restart_seen_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_oe_init: assert property (init_phase1 [*3] |-> !spi_miso_oe)
    else $error("miso driven in first init phase");
  chk_oe_idle: assert property (spi_cs_n [*8] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  chk_oe_rise: assert property ($rose(spi_miso_oe) |-> !$past(spi_cs_n) && !$past(spi_cs_n, 3))
    else $error("miso enabled without select");
  chk_osc_high: assert property ((osc_running && osc_compare_fail) [*4] ##0 spi_miso_oe |-> spi_miso)
    else $error("miso low during oscillator fault");
  chk_clr_restart: assert property (clear_fault_pulse && !init_busy && !init_phase1 |-> ##[0:1] !restart_seen_flag)
    else $error("restart flag not cleared");
  chk_restart_keep: assert property ($fell(restart_seen_flag) |-> clear_fault_pulse || $past(clear_fault_pulse))
    else $error("restart flag fell without clear");
  chk_restart_init: assert property (restart_seen_flag && init_phase1 |=> restart_seen_flag)
    else $error("restart flag cleared during init");
  chk_reset_vals: assert property ($fell(sys_rst) |-> restart_seen_flag && !spi_miso_oe && !selftest_enable_bit)
    else $error("wrong state after reset");
  chk_ctrl_idle: assert property ($changed({filter_bypass_bit, selftest_direction_bit, selftest_enable_bit})
    |-> $past(spi_cs_n) && $past(spi_cs_n, 3))
    else $error("control changed inside a frame");
endmodule : sscf_top_asserts
bind sscf_top sscf_top_asserts u_chk (.clk, .sys_rst, .spi_cs_n, .spi_miso, .spi_miso_oe, .init_phase1,
  .init_busy, .osc_running, .osc_compare_fail, .filter_bypass_bit, .selftest_direction_bit,
  .selftest_enable_bit, .clear_fault_pulse, .restart_seen_flag);
`default_nettype wire

// file: verification/sscf_spi_master.sv
// Behavioural serial master that frames commands and gathers replies
`timescale 1ns/10ps
`default_nettype none
module sscf_spi_master (
  // Clock
  input wire logic clk,
  // Slave output and enable
  input wire logic miso,
  input wire logic miso_oe,
  // Master pins
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  logic [15:0] rx_q;
  int cnt;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    rx_q = 16'h0000;
    cnt = 0;
  end
  task automatic frame(input logic [15:0] cmd, input int n);
    logic [15:0] sh;
    sh = cmd;
    @(posedge clk);
    cs_n <= 1'b0;
    mosi <= sh[15];
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      // Undriven line reads as inverse of last bit
      rx_q <= {rx_q[14:0], miso_oe ? miso : ~rx_q[0]};
      sclk <= 1'b0;
      sh = sh << 1;
      mosi <= sh[15];
      repeat (4) @(posedge clk);
    end
    cnt = n;
    cs_n <= 1'b1;
    mosi <= ~mosi;
    repeat (16) @(posedge clk);
  endtask : frame
endmodule : sscf_spi_master
`default_nettype wire

// file: verification/sscf_top_tb.sv
// Self-checking bench for the serial command frame slave
`timescale 1ns/10ps
`default_nettype none
module sscf_top_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic init_phase1 = 1'b1;
  logic osc_running = 1'b0;
  logic osc_compare_fail = 1'b0;
  logic init_busy = 1'b1;
  logic [3:0] hw_f = 4'h0;
  logic [3:0] ctl_seen = 4'h0;
  logic [3:0] ctl_exp[$];
  wire [4:0] ext_a;
  wire fb;
  wire sd;
  wire se;
  wire rsf;
  wire [3:0] ctl_now = {rsf, fb, sd, se};
  logic [9:0] ax = 10'h000;
  logic [9:0] ay = 10'h000;
  logic [7:0] ed = 8'h00;
  wire spi_sclk;
  wire spi_cs_n;
  wire spi_mosi;
  wire spi_miso;
  wire spi_miso_oe;
  int seed = 32'h1AD3;
  int num_errors = 0;
  int n_compared = 0;
  logic [15:0] exp_q[$];
  always #20 clk = ~clk;
  sscf_top dut (.clk, .sys_rst, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe,
    .init_phase1, .init_busy, .osc_running, .osc_compare_fail, .temp_fault(hw_f[0]),
    .offset_x_fault(hw_f[1]), .offset_y_fault(hw_f[2]), .parity_fault(hw_f[3]), .accel_x(ax), .accel_y(ay),
    .ext_reg_addr(ext_a), .ext_reg_data(ed ^ {3'h0, ext_a}), .filter_bypass_bit(fb),
    .selftest_direction_bit(sd), .selftest_enable_bit(se), .clear_fault_pulse(), .restart_seen_flag(rsf));
  sscf_spi_master mst (.clk, .miso(spi_miso), .miso_oe(spi_miso_oe), .sclk(spi_sclk), .cs_n(spi_cs_n),
    .mosi(spi_mosi));
  // ****
  // Helpers
  // ****
  function automatic logic [15:0] mk(input logic [2:0] t, input logic [1:0] s, input logic [9:0] d);
    logic [15:0] w;
    w = {t, 1'b0, s, d};
    w[12] = ~^w;
    return w;
  endfunction : mk
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_ctl(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_ctl
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // Only whole frames leave a note
  task automatic xf(input logic [15:0] c, input int n, input logic [15:0] e);
    if (n == 16) exp_q.push_back(e);
    mst.frame(c, n);
  endtask : xf
  always @(posedge spi_cs_n) begin
    if (mst.cnt == 16 && exp_q.size() > 0) cmp(mst.rx_q, exp_q.pop_front());
  end
  // Restart flag and control bits move only where a note expects them
  always @(posedge clk) begin
    if (!sys_rst && ctl_now !== ctl_seen) begin
      cmp_ctl(ctl_now, (ctl_exp.size() > 0) ? ctl_exp.pop_front() : 4'hX);
    end
    ctl_seen <= ctl_now;
  end
  initial begin
    #400000;
    num_errors++;
    close_out();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    logic [15:0] rq;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    ax <= 10'($random(seed));
    ay <= 10'($random(seed));
    ed <= 8'($random(seed));
    repeat (4) @(posedge clk);
    mst.frame(16'h4007, 16);
    init_phase1 <= 1'b0;
    repeat (4) @(posedge clk);
    rq = mk(3'h0, sscf_pkg::ST_ERR, 10'h001);
    xf(16'h8000, 16, rq);
    ctl_exp.push_back(4'hF);
    xf(16'h4007, 16, mk(3'h4, sscf_pkg::ST_DATA, 10'h000));
    xf(16'h4100, 16, mk(3'h2, sscf_pkg::ST_DATA, 10'h007));
    xf(16'hC000, 16, rq);
    init_busy <= 1'b0;
    xf(16'h0000, 16, mk(3'h6, sscf_pkg::ST_DATA, 10'h021));
    xf(16'h2000, 16, rq);
    xf(16'h6000, 16, mk(3'h0, sscf_pkg::ST_ERR, 10'h010));
    xf(16'hA000, 16, mk(3'h1, sscf_pkg::ST_SELF, ay));
    ctl_exp.push_back(4'h0);
    xf(16'h4008, 16, mk(3'h0, sscf_pkg::ST_ERR, 10'h004));
    xf(16'h2000, 16, mk(3'h2, sscf_pkg::ST_DATA, 10'h000));
    xf(16'h9000, 16, mk(3'h0, sscf_pkg::ST_DATA, ax));
    xf(16'h9000, 15, 16'h0000);
    hw_f <= 4'h1 << 2'($random(seed));
    xf(16'h2000, 16, mk(3'h0, sscf_pkg::ST_ERR, 10'h002));
    xf({8'h85, 8'($random(seed))}, 16, mk(3'h0, sscf_pkg::ST_ERR, 10'h008));
    hw_f <= 4'h0;
    xf(16'h0000, 16, mk(3'h4, sscf_pkg::ST_DATA, {2'b00, ed ^ 8'h05}));
    osc_running <= 1'b1;
    osc_compare_fail <= 1'b1;
    xf(16'h8000, 16, 16'hFFFF);
    close_out();
  end
endmodule : sscf_top_tb
`default_nettype wire
